// ### rtl/lcs_cascade_sync.sv
// Cascade index and backplane frame sync for one LCD driver.
// Assumes an APB master on pclk and synchronous pin inputs; the
// sync line is shared open drain with a pull-up outside.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcs_cascade_sync
  import lcs_pkg::*;
#(
  parameter int unsigned OSC_DIV = OSC_DIV_CYC  // Display clock divider.
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              hw_subaddr_bit0,
  input  wire logic              hw_subaddr_bit1,
  input  wire logic              hw_subaddr_bit2,
  input  wire logic              osc_ext_sel,
  input  wire logic              clk_pin_i,
  output logic                   clk_pin_o,
  output logic                   clk_pin_oe,
  input  wire logic              sync_n_i,
  output logic                   sync_n_o,
  output logic                   sync_n_oe,
  output logic                   backplane_out_0,
  output logic                   backplane_out_1,
  output logic                   backplane_out_2,
  output logic                   backplane_out_3,
  output logic [IDX_W-1:0]       cascade_index
);

  // ==========================================================
  // State of the block.

  // All registers live in one struct.
  typedef struct packed {
    logic                enable;      // Phase logic running.
    logic                sa_bit;      // Slave address select bit.
    lcs_mux_e            mux;         // Multiplex mode.
    logic                master;      // Clock master configuration.
    logic                use_ext;     // Display clock from the pin.
    logic                clk_oe;      // Drive the clock pin.
    logic [PHASE_W-1:0]  phase;       // Current backplane phase.
    logic [NUM_BP-1:0]   bp;          // Active backplane, one-hot.
    logic                drive;       // Pulling the sync line.
    logic                drive_prev;  // Pulled it one cycle ago.
    logic                sync_s;      // Sampled sync line.
    logic                resync;      // Sticky realignment flag.
    logic [IDX_W-1:0]    idx;         // Cascade index.
    logic [31:0]         rdata;       // Read data for the access.
    logic                slverr;      // Error for the access.
  } lcs_core_s;

  // Reset image; phase zero on every driver keeps a cascade aligned.
  // Backplanes stay dark in reset and light at the first edge after it.
  localparam lcs_core_s RST = '{
    enable:     RST_EN,
    sa_bit:     RST_SA,
    mux:        RST_MUX,
    master:     RST_MASTER,
    use_ext:    !RST_MASTER,
    clk_oe:     RST_MASTER,
    sync_s:     SYNC_IDLE,
    default:    '0
  };

  lcs_core_s s_q;      // Registered state.
  lcs_core_s s_d;      // Next state.
  logic      apb_setup;   // Setup cycle of a transfer.
  logic      apb_access;  // Access cycle of a transfer.
  logic      ctrl_wr;     // Write to the control register.
  logic      stat_wr;     // Write to the status register.
  logic      ext_low;     // Another driver pulls the line.

  // ==========================================================
  // Helpers.

  // Index of the last active backplane for a mode.
  // The mode code is the last phase index, so a cast is enough.
  function automatic logic [PHASE_W-1:0] last_phase(input lcs_mux_e m);
    last_phase = PHASE_W'(m);
  endfunction

  // One-hot backplane select for a phase.
  function automatic logic [NUM_BP-1:0] bp_onehot(input logic [PHASE_W-1:0] p);
    logic [NUM_BP-1:0] r;
    r    = '0;
    r[p] = 1'b1;
    return r;
  endfunction

  // ==========================================================
  // Tick generator.

  lcs_tick_if tk ();

  lcs_tick_gen #(
    .DIV        (OSC_DIV)
  ) u_tick (
    .pclk       (pclk),
    .presetn    (presetn),
    .ext_clk_in (clk_pin_i),
    .tk         (tk)
  );

  // ==========================================================
  // Bus decode.

  // The slave never waits, so every access ends in its first cycle.
  // Only byte lane zero holds fields, so its strobe gates every write.
  assign apb_setup  = psel && !penable;
  assign apb_access = psel && penable;
  assign ctrl_wr    = apb_access && pwrite && (paddr == ADDR_CTRL) && pstrb[0];
  assign stat_wr    = apb_access && pwrite && (paddr == ADDR_STATUS) && pstrb[0];

  // A low line seen while we have not pulled it for two cycles is
  // someone else; the guard covers our own release delay.
  // A pull shorter than one clock can be missed; peers hold it longer.
  assign ext_low = s_q.enable && !s_q.sync_s && !s_q.drive && !s_q.drive_prev;

  // ==========================================================
  // Next state.

  // One process computes every next value.
  always_comb begin
    s_d = s_q;

    // Configuration from software.
    // A mode change takes effect at once; no frame boundary is awaited.
    if (ctrl_wr) begin
      s_d.enable = pwdata[CTRL_EN_BIT];
      s_d.sa_bit = pwdata[CTRL_SA_BIT];
      s_d.mux    = lcs_mux_e'(pwdata[CTRL_MUX_LSB +: PHASE_W]);
      s_d.master = pwdata[CTRL_MASTER_BIT];
    end

    // A slave or an externally clocked driver listens to the pin.
    s_d.use_ext = osc_ext_sel || !s_d.master;
    s_d.clk_oe  = s_d.master && !osc_ext_sel;

    // Index pins are taken as synchronous and need no second stage.
    // Address bit on top of the three pins, 0..15 over two clusters.
    s_d.idx = {s_q.sa_bit, hw_subaddr_bit2, hw_subaddr_bit1,
               hw_subaddr_bit0};

    // Sample the line once; pins are synchronous already.
    s_d.sync_s     = sync_n_i;
    s_d.drive_prev = s_q.drive;

    // Phase counter; a realign wins over a tick in the same cycle, so
    // the first puller sets the pace for the whole cascade.
    if (!s_d.enable) begin
      s_d.phase = '0;
    end else if (ext_low) begin
      // First puller wins; jump to the last phase.
      s_d.phase = last_phase(s_d.mux);
    end else if (tk.tick) begin
      // Wrap also recovers a phase beyond a newly shortened mode.
      if (s_q.phase >= last_phase(s_d.mux)) begin
        s_d.phase = '0;
      end else begin
        s_d.phase = s_q.phase + PHASE_W'(1);
      end
    end

    // Pull the line for the whole last phase.
    s_d.drive = s_d.enable && (s_d.phase == last_phase(s_d.mux));
    s_d.bp    = s_d.enable ? bp_onehot(s_d.phase) : '0;

    // Sticky flag: write one clears, a new event wins the same cycle.
    if (stat_wr && pwdata[ST_RESYNC_BIT]) begin
      s_d.resync = 1'b0;
    end
    if (ext_low) begin
      s_d.resync = 1'b1;
    end

    // Read data is prepared in setup so it comes from a flop.
    if (apb_setup) begin
      s_d.rdata  = '0;
      s_d.slverr = 1'b0;
      unique case (paddr)
        ADDR_CTRL: begin
          s_d.rdata[CTRL_EN_BIT]                 = s_q.enable;
          s_d.rdata[CTRL_SA_BIT]                 = s_q.sa_bit;
          s_d.rdata[CTRL_MUX_LSB +: PHASE_W]     = s_q.mux;
          s_d.rdata[CTRL_MASTER_BIT]             = s_q.master;
        end
        ADDR_STATUS: begin
          s_d.rdata[ST_IDX_LSB +: IDX_W]         = s_q.idx;
          s_d.rdata[ST_PHASE_LSB +: PHASE_W]     = s_q.phase;
          s_d.rdata[ST_DRIVE_BIT]                = s_q.drive;
          s_d.rdata[ST_RESYNC_BIT]               = s_q.resync;
        end
        default: begin
          // Unmapped address: error, data reads zero.
          s_d.slverr = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Registers.

  // Asynchronous reset loads the constant image only.
  // Keeping the reset branch constant avoids a reset-to-data path.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs.

  // Ready is combinational; read data and error come from flops.
  assign pready  = 1'b1;
  assign prdata  = s_q.rdata;
  assign pslverr = s_q.slverr;

  // Open drain: the value is always the pulled level.
  // Only the enable is timed; the pin value itself never changes.
  assign sync_n_o  = SYNC_PULL;
  assign sync_n_oe = s_q.drive;

  assign tk.use_ext      = s_q.use_ext;
  assign clk_pin_o       = tk.clk_level;
  assign clk_pin_oe      = s_q.clk_oe;
  assign backplane_out_0 = s_q.bp[0];
  assign backplane_out_1 = s_q.bp[1];
  assign backplane_out_2 = s_q.bp[2];
  assign backplane_out_3 = s_q.bp[3];
  assign cascade_index   = s_q.idx;

  // ==========================================================
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // The reset image is exempt for one edge where it differs from run state.

  a_index_map: assert property (
    $past(presetn) |-> cascade_index ==
      {$past(s_q.sa_bit), $past(hw_subaddr_bit2),
       $past(hw_subaddr_bit1), $past(hw_subaddr_bit0)})
    else $error("cascade index does not follow address bit and pins");

  a_drive_last: assert property (
    sync_n_oe == (s_q.enable && s_q.phase == last_phase(s_q.mux)))
    else $error("sync pulled outside the last phase");

  a_realign_jump: assert property (
    (ext_low && !ctrl_wr) |=> (s_q.phase == last_phase(s_q.mux)) && sync_n_oe)
    else $error("no realignment after external sync");

  a_reset_phase: assert property (
    $rose(presetn) |-> s_q.phase == '0 && !sync_n_oe)
    else $error("phase not zero after reset");

  a_open_drain: assert property (
    sync_n_oe |-> sync_n_o == SYNC_PULL)
    else $error("sync driven high");

  a_resync_flag: assert property (
    ext_low |=> s_q.resync)
    else $error("realignment flag not set");

  a_resync_hold: assert property (
    (s_q.resync && !(stat_wr && pwdata[ST_RESYNC_BIT])) |=> s_q.resync)
    else $error("realignment flag dropped without a clear");

  a_phase_step: assert property (
    (tk.tick && s_q.enable && !ext_low && !ctrl_wr) |=>
      s_q.phase == (($past(s_q.phase) >= last_phase($past(s_q.mux))) ?
                    PHASE_W'(0) : $past(s_q.phase) + PHASE_W'(1)))
    else $error("phase did not step on tick");

  a_phase_hold: assert property (
    (!tk.tick && s_q.enable && !ext_low && !ctrl_wr) |=> $stable(s_q.phase))
    else $error("phase moved without tick");

  a_bp_onehot: assert property (
    (s_q.enable && $past(presetn)) |-> s_q.bp == bp_onehot(s_q.phase))
    else $error("backplane select not one-hot of phase");

  c_resync: cover property (ext_low ##1 sync_n_oe);
  c_quad_last: cover property (s_q.mux == MUX_QUAD && $rose(sync_n_oe));
  c_ext_clock: cover property (s_q.use_ext && tk.tick);
  c_bad_addr: cover property (apb_access && pslverr);

endmodule
`default_nettype wire

// ### rtl/lcs_pkg.sv
// Constants shared by the cascade addressing and frame sync logic.
// Assumes a single 125 MHz APB clock domain and synchronous pin inputs.
//
// Functional notes
// - sixteen drivers share one bus, each uniquely.
// - index is address bit over three subaddress pins.
// - pull sync low in last phase, watch otherwise.
// - on lost alignment follow first sync puller.
// - reset starts every driver in the same phase.
// - sync pin only pulls low, pull-up restores.
package lcs_pkg;
  // ==========================================================
  // Clocking.
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;  // Bus clock rate.
  localparam int unsigned OSC_TYP_HZ  = 1970;         // Internal display clock.
  localparam int unsigned OSC_DIV_CYC = CLK_FREQ_HZ / OSC_TYP_HZ;

  // ==========================================================
  // Widths.
  localparam int APB_AW  = 12;  // Address bits decoded.
  localparam int IDX_W   = 4;   // Cascade index width.
  localparam int PHASE_W = 2;   // Backplane phase width.
  localparam int NUM_BP  = 4;   // Backplane outputs.

  // ==========================================================
  // Register map and field layout.
  localparam logic [APB_AW-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;
  localparam int CTRL_EN_BIT     = 0;  // Phase logic enable.
  localparam int CTRL_SA_BIT     = 1;  // Slave address select bit.
  localparam int CTRL_MUX_LSB    = 2;  // Two-bit multiplex mode.
  localparam int CTRL_MASTER_BIT = 4;  // This driver is clock master.
  localparam int ST_IDX_LSB      = 0;  // Four-bit cascade index.
  localparam int ST_PHASE_LSB    = 4;  // Current backplane phase.
  localparam int ST_DRIVE_BIT    = 6;  // Sync line pulled by us.
  localparam int ST_RESYNC_BIT   = 7;  // Sticky realignment seen.

  // Multiplex modes; the code equals the index of the last phase.
  typedef enum logic [PHASE_W-1:0] {
    MUX_STATIC,
    MUX_DUPLEX,
    MUX_TRIPLEX,
    MUX_QUAD
  } lcs_mux_e;

  // ==========================================================
  // Reset values and line levels.
  localparam logic     RST_EN     = 1'b1;  // Run straight out of reset.
  localparam logic     RST_SA     = 1'b0;
  localparam logic     RST_MASTER = 1'b0;
  localparam lcs_mux_e RST_MUX    = MUX_QUAD;
  localparam logic     SYNC_IDLE  = 1'b1;  // Pulled-up line level.
  localparam logic     SYNC_PULL  = 1'b0;  // Only level ever driven.
endpackage

// ### rtl/lcs_tick_if.sv
// Display clock hand-off between the tick generator and the core.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
`default_nettype none
interface lcs_tick_if;
  logic use_ext;    // Take the clock pin instead of the divider.
  logic tick;       // One-cycle display clock event.
  logic clk_level;  // Divided square wave for the clock pin.
  modport gen  (input use_ext, output tick, output clk_level);
  modport core (output use_ext, input tick, input clk_level);
endinterface
`default_nettype wire

// ### rtl/lcs_tick_gen.sv
// Display clock source: internal divider or the shared clock pin.
// Assumes the clock pin input is already synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module lcs_tick_gen
  import lcs_pkg::*;
#(
  parameter int unsigned DIV = OSC_DIV_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ext_clk_in,
  lcs_tick_if.gen  tk
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] CNT_HALF = CW'(DIV / 2);

  // ==========================================================
  // State.
  typedef struct packed {
    logic [CW-1:0] cnt;    // Divider count.
    logic          level;  // Square wave for a clock master.
    logic          ext_s;  // Clock pin one cycle ago.
    logic          tick;   // Registered display clock event.
  } lcs_gen_s;

  lcs_gen_s s_q;
  lcs_gen_s s_d;

  // Next state: the divider always runs so a master keeps driving.
  always_comb begin
    s_d       = s_q;
    s_d.ext_s = ext_clk_in;
    s_d.cnt   = (s_q.cnt == CNT_LAST) ? '0 : s_q.cnt + CW'(1);
    s_d.level = (s_d.cnt < CNT_HALF);
    if (tk.use_ext) begin
      // Rising edge of the shared clock pin.
      s_d.tick = ext_clk_in && !s_q.ext_s;
    end else begin
      s_d.tick = (s_q.cnt == CNT_LAST);
    end
  end

  // Register the whole state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tk.tick      = s_q.tick;
  assign tk.clk_level = s_q.level;

  // ==========================================================
  // Checks.
  a_tick_single: assert property (
    @(posedge pclk) disable iff (!presetn) tk.tick |=> !tk.tick)
    else $error("display tick lasted more than one cycle");
  a_div_period: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!tk.use_ext && s_q.cnt == CNT_LAST) |=> tk.tick)
    else $error("divider wrap gave no tick");
  c_ext_tick: cover property (
    @(posedge pclk) disable iff (!presetn) tk.use_ext && tk.tick);
endmodule
`default_nettype wire

// ### dv/lcs_peer_model.sv
// Model of a second cascaded driver on the shared sync and clock pins.
// Assumes the bench resolves both wired lines from all output enables.
`timescale 1ns/1ps
`default_nettype none
module lcs_peer_model #(
  parameter int HALF = 8,  // Half period of the shared display clock.
  parameter int PULL = 2   // Cycles the line is held low per pull.
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clk_en,
  input  wire logic pull_req,
  output logic      clk_o,
  output logic      clk_oe,
  output logic      sync_oe
);
  // ==========================================================
  // Clock source; it stands still while not the master.
  int div_q;  // Half period counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 0;
      clk_o  <= 1'b0;
      clk_oe <= 1'b0;
    end else begin
      clk_oe <= clk_en;  // Only one source drives the pin.
      div_q  <= (div_q == HALF - 1) ? 0 : div_q + 1;
      if (clk_en && div_q == HALF - 1) begin
        clk_o <= !clk_o;
      end
    end
  end
  // ==========================================================
  // Sync puller; a request stands for this driver's last phase.
  int pull_q;  // Remaining pull cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_q <= 0;
    end else if (pull_req) begin
      pull_q <= PULL;  // Pull at the onset of the last phase.
    end else if (pull_q > 0) begin
      pull_q <= pull_q - 1;
    end
  end
  assign sync_oe = (pull_q > 0);  // Only ever pulls low.
endmodule
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the cascade index and frame sync block.
// Assumes the peer model shares the sync and clock pins with the design.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lcs_pkg::*;
  localparam int DIV = 8;  // Short display clock divider.
  logic              pclk, presetn, psel, penable, pwrite, osc_ext_sel;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [2:0]        sub;
  logic              peer_en, pull_req, pready, pslverr;
  logic              clk_o, clk_oe, sync_o, sync_oe, pclk_o, pclk_oe, psync_oe;
  logic [3:0]        bp;
  logic [IDX_W-1:0]  idx;
  int                err_total, checks;
  // ==========================================================
  // Wired lines: pull-up on sync, the clock from whoever drives it.
  wire sync_w = !((sync_oe && !sync_o) || psync_oe);
  wire clk_w  = clk_oe ? clk_o : (pclk_oe ? pclk_o : 1'b0);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = !pclk;
  end
  lcs_cascade_sync #(.OSC_DIV(DIV)) lcs_cascade_sync_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .hw_subaddr_bit0(sub[0]), .hw_subaddr_bit1(sub[1]),
    .hw_subaddr_bit2(sub[2]), .osc_ext_sel(osc_ext_sel), .clk_pin_i(clk_w),
    .clk_pin_o(clk_o), .clk_pin_oe(clk_oe), .sync_n_i(sync_w), .sync_n_o(sync_o),
    .sync_n_oe(sync_oe), .backplane_out_0(bp[0]), .backplane_out_1(bp[1]),
    .backplane_out_2(bp[2]), .backplane_out_3(bp[3]), .cascade_index(idx));
  lcs_peer_model #(.HALF(DIV), .PULL(2)) lcs_peer_model_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(peer_en), .pull_req(pull_req),
    .clk_o(pclk_o), .clk_oe(pclk_oe), .sync_oe(psync_oe));
  // ==========================================================
  // Reporting.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Bus and wait helpers; every wait is bounded.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic wait_bp(input logic [3:0] old, output logic [3:0] nw);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (bp === old && n < 400);
    if (n >= 400) begin
      err_total++;
      conclude();
    end
    nw = bp;
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(bp, 4'b0001, "reset phase");
  endtask
  // Runs one multiplex mode as a slave; the task counts phases itself.
  task automatic walk(input int m);
    logic [3:0] cur, nw;
    int         ph;
    do_reset();
    wr(ADDR_CTRL, ($urandom & 32'hFFFF_FFE0) | 32'(m << 2) | 32'h1);
    ph = 0;
    cur = 4'b0001;
    if (m == 0) begin
      repeat (40) @(posedge pclk);
      check(bp, 4'b0001, "static phase");
      check(sync_oe, 1'b1, "static pull");
    end
    for (int k = 0; m > 0 && k < 2 * (m + 1); k++) begin
      wait_bp(cur, nw);
      ph = (ph + 1) % (m + 1);
      check(nw, 32'(1 << ph), "phase step");
      @(posedge pclk);
      check(sync_oe, ph == m, "sync pull");
      check(sync_o, 1'b0, "open drain");
      cur = nw;
    end
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    logic [31:0] r;
    logic        e;
    logic [3:0]  nw;
    logic [3:0]  cur;
    int          n;
    presetn = 1'b0;
    {psel, penable, pwrite, pull_req} = '0;
    paddr = '0;
    pwdata = '0;
    sub = 3'h0;
    osc_ext_sel = 1'b0;
    peer_en = 1'b1;
    err_total = 0;
    checks = 0;
    void'($urandom(32'h20A3));
    do_reset();
    apb(1'b0, ADDR_CTRL, 32'h0, r, e);
    check(r, 32'h0000_000D, "ctrl reset");
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    check(r, 32'h0, "status reset");
    apb(1'b0, 12'h008, 32'h0, r, e);
    check(e, 1'b1, "unmapped error");
    check(r, 32'h0, "unmapped data");
    for (int i = 0; i < 16; i++) begin
      sub <= 3'(i);
      wr(ADDR_CTRL, 32'h0D | 32'((i >> 3) << 1));
      repeat (2) @(posedge pclk);
      check(idx, 32'(i), "index pins");
      apb(1'b0, ADDR_STATUS, 32'h0, r, e);
      check(r[3:0], 32'(i), "index status");
    end
    for (int m = 0; m < 4; m++) walk(m);
    n = 0;
    while (bp !== 4'b0010 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) begin
      err_total++;
      conclude();
    end
    pull_req <= 1'b1;
    @(posedge pclk);
    pull_req <= 1'b0;
    wait_bp(4'b0010, nw);
    check(nw, 4'b1000, "realign");
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    check(r[7], 1'b1, "resync flag");
    wr(ADDR_STATUS, 32'h80);
    apb(1'b0, ADDR_STATUS, 32'h0, r, e);
    check(r[7], 1'b0, "resync clear");
    wait_bp(bp, nw);
    check(nw, 4'b0001, "wrap after realign");
    peer_en <= 1'b0;
    wr(ADDR_CTRL, 32'h1D);
    repeat (3) @(posedge pclk);
    check(clk_oe, 1'b1, "master drives clock");
    osc_ext_sel <= 1'b1;
    peer_en <= 1'b1;
    repeat (3) @(posedge pclk);
    check(clk_oe, 1'b0, "external clock in");
    cur = bp;
    wait_bp(cur, nw);
    check(nw, {cur[2:0], cur[3]}, "external ticks");
    conclude();
  end
endmodule
`default_nettype wire
